// ---- uls_consts.vh ----
// Purpose: Constants for the serial loopback selector.
// Assumes: APB slave with 32-bit data and one register word.
// Notes: Offset is the printed address, which is not a multiple of four, so it is an index.
//
// Function
// RULE1: Loopback bit one routes the channel transmit output into its own receiver.
// RULE2: Loopback bit zero feeds the receiver from the channel external receive pin.
// RULE3: Independent bit per channel: bits 5,4 standalone ch1,ch0; bits 3..0 array ch3..0.
// RULE4: Reset clears the loopback select register to all zeros.
// RULE5: Register accepts single-bit writes and full byte-wide writes.
// RULE6: Software writes zero to reserved bits 7 and 6.
// RULE7: Loopback changes only that channel's receive source; transmit and others unaffected.
`ifndef ULS_CONSTS_VH
`define ULS_CONSTS_VH

// Printed offset kept as index; byte address is four times it.
`define ULS_LOOPBACK_INDEX     20'hF0079
`define ULS_LOOPBACK_ADDR      22'h3C01E4
// Bit-set and bit-clear alias registers, byte addresses.
`define ULS_BITSET_ADDR        22'h3C01E8
`define ULS_BITCLR_ADDR        22'h3C01EC
// Word indices of the two alias addresses, as seen on paddr[21:2].
`define ULS_BITSET_INDEX       20'hF007A
`define ULS_BITCLR_INDEX       20'hF007B
// Field layout.
`define ULS_CHANNELS           6
`define ULS_REG_WIDTH          8
`define ULS_FIELD_MASK         8'h3F
`define ULS_RESET_VALUE        8'h00
`define ULS_ZERO_WORD          32'h00000000
// Bit positions.
`define ULS_BIT_STD_CH1        5
`define ULS_BIT_STD_CH0        4

`endif

// ---- uls_rx_mux.v ----
// Purpose: Per-channel receive source selector.
// Assumes: Pins and transmit outputs are synchronous to pclk.
// Notes: Output is registered so the top drives receivers from flip-flops.
`timescale 1ns/1ps
`default_nettype none
module uls_rx_mux #(
    parameter CHANNELS = 6
) (
    // Clock and reset.
    input  wire                pclk,
    input  wire                presetn,
    // Select and sources.
    input  wire [CHANNELS-1:0] loop_sel,
    input  wire [CHANNELS-1:0] pin_rx,
    input  wire [CHANNELS-1:0] tx_shift_out,
    // Receive shift register inputs.
    output reg  [CHANNELS-1:0] rx_shift_in
);
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
            // Each channel picks its own source; idle line is high at reset.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_shift_in[g] <= 1'b1;
                end else if (loop_sel[g]) begin
                    rx_shift_in[g] <= tx_shift_out[g]; // RULE1 RULE7
                end else begin
                    rx_shift_in[g] <= pin_rx[g]; // RULE2
                end
            end
        end
    endgenerate
endmodule // uls_rx_mux
`default_nettype wire

// ---- uls_apb_if.v ----
// Purpose: APB slave front end with one-wait-free decode.
// Assumes: APB3 signalling; pready answers in the access phase.
// Notes: Produces one-cycle access and write strobes plus three address hit decodes.
`include "uls_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module uls_apb_if (
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    // Decoded strobes.
    output wire        acc,
    output wire        wr,
    output wire        hit_reg,
    output wire        hit_set,
    output wire        hit_clr
);
    // Decode the word address; low two bits ignored.
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign hit_reg = (paddr[21:2] == `ULS_LOOPBACK_INDEX) && (paddr[31:22] == 10'h000);
    assign hit_set = (paddr[21:2] == `ULS_BITSET_INDEX) && (paddr[31:22] == 10'h000);
    assign hit_clr = (paddr[21:2] == `ULS_BITCLR_INDEX) && (paddr[31:22] == 10'h000);
endmodule // uls_apb_if
`default_nettype wire

// ---- uls_loopback_select.v ----
// Purpose: Loopback selector for six serial channels, reached over APB.
// Assumes: One clock pclk at 125 MHz; asynchronous active-low reset.
// Notes: Receivers are fed one pclk after their source, never combinationally.
//
// Chosen here: the APB interface to the registers.
`include "uls_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module uls_loopback_select #(
    parameter CHANNELS = `ULS_CHANNELS
) (
    // Clock and reset.
    input  wire                pclk,
    input  wire                presetn,
    // APB slave.
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [31:0]         paddr,
    input  wire [31:0]         pwdata,
    input  wire [3:0]          pstrb,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    // External receive pins: array ch0..3 then standalone ch0..1.
    input  wire [CHANNELS-1:0] pin_rx,
    // Transmit shift register outputs, same order.
    input  wire [CHANNELS-1:0] tx_shift_out,
    // Receive shift register inputs, same order.
    output wire [CHANNELS-1:0] rx_shift_in,
    // Current select bits for the channel logic.
    output reg  [CHANNELS-1:0] loop_sel_out
);
    wire acc;
    wire wr;
    wire hit_reg;
    wire hit_set;
    wire hit_clr;
    reg  [`ULS_REG_WIDTH-1:0] serial_loopback_select;
    reg  [`ULS_REG_WIDTH-1:0] next_sel;
    reg  [`ULS_REG_WIDTH-1:0] wmask;

    uls_apb_if u_apb (
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .acc     (acc),
        .wr      (wr),
        .hit_reg (hit_reg),
        .hit_set (hit_set),
        .hit_clr (hit_clr)
    );

    // Next register value: byte write, or masked bit-set/bit-clear aliases.
    always @* begin
        wmask    = pwdata[`ULS_REG_WIDTH-1:0] & `ULS_FIELD_MASK; // RULE6
        next_sel = serial_loopback_select;
        if (wr && hit_reg && pstrb[0]) begin
            next_sel = wmask; // RULE5
        end else if (wr && hit_set && pstrb[0]) begin
            next_sel = serial_loopback_select | wmask; // RULE5
        end else if (wr && hit_clr && pstrb[0]) begin
            next_sel = serial_loopback_select & ~wmask; // RULE5
        end
    end

    // Register and bus answers; zero-wait, unmapped access errors.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_loopback_select <= `ULS_RESET_VALUE; // RULE4
            loop_sel_out           <= {CHANNELS{1'b0}};
            prdata                 <= `ULS_ZERO_WORD;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
        end else begin
            serial_loopback_select <= next_sel; // RULE3
            loop_sel_out           <= next_sel[CHANNELS-1:0];
            pready                 <= psel & ~penable;
            pslverr                <= psel & ~penable & ~(hit_reg | hit_set | hit_clr);
            if (psel && !penable && !pwrite && (hit_reg || hit_set || hit_clr)) begin
                prdata <= {24'h000000, serial_loopback_select};
            end else begin
                prdata <= `ULS_ZERO_WORD;
            end
        end
    end

    // Receive source selection per channel.
    uls_rx_mux #(
        .CHANNELS (CHANNELS)
    ) u_mux (
        .pclk         (pclk),
        .presetn      (presetn),
        .loop_sel     (serial_loopback_select[CHANNELS-1:0]), // RULE3 RULE7
        .pin_rx       (pin_rx),
        .tx_shift_out (tx_shift_out),
        .rx_shift_in  (rx_shift_in)
    );
endmodule // uls_loopback_select
`default_nettype wire

// ---- uls_checker.sv ----
// Purpose: Port assertions for the loopback selector.
// Assumes: One clock; presetn low resets.
// Notes: Path checks wait for a settled select, which may show a cycle late.
`timescale 1ns/1ps
`default_nettype none
`include "uls_consts.vh"
module uls_checker #(parameter CHANNELS = 6) (
    // Watched ports, packed per type to keep the file short.
    input wire logic                pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [31:0]         paddr, pwdata, prdata,
    input wire logic [3:0]          pstrb,
    input wire logic [CHANNELS-1:0] pin_rx, tx_shift_out, rx_shift_in, loop_sel_out
);
    // A write is taken only at a ready access edge with the low strobe set.
    wire wr = psel && penable && pwrite && pready && pstrb[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_loop_path: assert property ($stable(loop_sel_out) && $past(presetn) |->
        ((rx_shift_in ^ $past(tx_shift_out)) & $past(loop_sel_out)) == 0) else $error("Bad loop.");
    a_pin_path: assert property ($stable(loop_sel_out) && $past(presetn) |->
        ((rx_shift_in ^ $past(pin_rx)) & ~$past(loop_sel_out)) == 0) else $error("Bad pin.");
    a_reset_clear: assert property ($rose(presetn) |-> loop_sel_out == 0)
        else $error("Select not clear.");
    a_read_upper: assert property (
        psel && penable && !pwrite && pready |-> prdata[31:6] == 0) else $error("Upper set.");
    a_main_write: assert property (wr && paddr == `ULS_LOOPBACK_ADDR |=> ##1
        loop_sel_out == $past(pwdata[CHANNELS-1:0], 2)) else $error("Write lost.");
    a_set_bits: assert property (wr && paddr == `ULS_BITSET_ADDR |=> ##1
        &(loop_sel_out | ~$past(pwdata[CHANNELS-1:0], 2))) else $error("Set lost.");
endmodule // uls_checker
bind uls_loopback_select uls_checker #(.CHANNELS(CHANNELS)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .pin_rx(pin_rx),
    .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in), .loop_sel_out(loop_sel_out));
`default_nettype wire

// ---- uls_far.sv ----
// Purpose: Far-side transmitters and receive pins.
// Assumes: Same bit order as the selector.
// Notes: Sources move every cycle.
`timescale 1ns/1ps
`default_nettype none
module uls_far (
    // Clock and sources.
    input  wire logic       pclk,
    output var  logic [5:0] tx,
    output var  logic [5:0] pin
);
    // Transmitters keep shifting whatever the select, so a stale path shows.
    initial tx = 6'h3F;
    always @(posedge pclk) begin
        tx  <= tx + 6'h05;
        pin <= ~tx ^ 6'h2A;
    end
endmodule // uls_far
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the loopback selector.
// Assumes: Bits 7 and 6 are always written as zero.
// Notes: Each test prints a line as it ends.
`timescale 1ns/1ps
`default_nettype none
`include "uls_consts.vh"
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, x); end end
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [5:0]  tx, pin, rx, sel;
    int          num_errors, n_compared, i;
    uls_far u_far (.pclk(pclk), .tx(tx), .pin(pin));
    uls_loopback_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_rx(pin), .tx_shift_out(tx),
        .rx_shift_in(rx), .loop_sel_out(sel));
    // One transfer, held until pready; data and error are taken at that edge.
    task automatic apb(input logic w, input logic [21:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, 10'h000, a, d, 4'hF};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Receivers take the selected source one cycle later.
    task automatic path(input logic [5:0] s);
        logic [5:0] x;
        @(negedge pclk);
        x = (s & tx) | (~s & pin);
        @(posedge pclk);
        #1 `CHK(rx, x)
    endtask
    task automatic t_byte();
        apb(1'b0, `ULS_LOOPBACK_ADDR, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b1, `ULS_LOOPBACK_ADDR, 32'h5A00002A);
        apb(1'b1, `ULS_LOOPBACK_ADDR + 22'h20, 32'h15);
        `CHK(e, 1'b1)
        apb(1'b0, `ULS_LOOPBACK_ADDR, 32'h0);
        `CHK(r, 32'h2A)
        path(6'h2A);
        apb(1'b1, `ULS_BITCLR_ADDR, 32'h3F);
        $display("byte test done");
    endtask
    task automatic t_bits();
        for (i = 0; i < 6; i++) begin
            apb(1'b1, `ULS_BITSET_ADDR, 32'h1 << i);
            apb(1'b0, `ULS_LOOPBACK_ADDR, 32'h0);
            `CHK(r, 32'h1 << i)
            path(6'h1 << i);
            apb(1'b1, `ULS_BITCLR_ADDR, 32'h1 << i);
        end
        $display("bit test done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard, far beyond the 23 transfers needed.
    initial begin
        #50us;
        num_errors++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_byte();
        t_bits();
        test_done();
    end
endmodule // tb
`default_nettype wire
